// ### rtl/wosl_pkg.sv
// Constants and types shared by the write-once security lock
package wosl_pkg;

   // ==========================================================
   // Latch geometry and match decision
   localparam int          LATCH_BITS    = 32;
   localparam int          COUNT_W       = 6;
   localparam logic [5:0]  MATCH_MIN     = 6'h1C;          // 28 agreeing bits
   // Lock pattern; value is arbitrary
   localparam logic [31:0] LOCK_PATTERN  = 32'hA5C3_96E1;
   // Nonvolatile cell contents after power-on; value is arbitrary
   localparam logic [31:0] NV_BLANK      = 32'h0000_0000;
   localparam logic [31:0] VOL_RESET     = 32'h0000_0000;
   localparam logic [31:0] RSP_RESET     = 32'h0000_0000;

   // ==========================================================
   // Flash block protection
   localparam int          FLASH_BLOCKS  = 8;
   localparam int          BLOCK_W       = 3;
   localparam int          LEVEL_W       = 2;
   localparam logic [1:0]  LVL_NONE      = 2'h0;
   localparam logic [1:0]  WRITE_MAX_LVL = 2'h0;            // Erase and program
   localparam logic [1:0]  VERIFY_MAX_LVL = 2'h1;           // Verify

   // ==========================================================
   // Commands from the debug port engine
   typedef enum logic [2:0] {
      WOSL_CMD_LOAD_KEY   = 3'h0,
      WOSL_CMD_COMMIT     = 3'h1,
      WOSL_CMD_READ_LATCH = 3'h2,
      WOSL_CMD_PROT_SET   = 3'h3,
      WOSL_CMD_CHIP_ERASE = 3'h4,
      WOSL_CMD_FLASH_OP   = 3'h5
   } wosl_cmd_t;

   typedef enum logic [1:0] {
      WOSL_FL_ERASE   = 2'h0,
      WOSL_FL_PROGRAM = 2'h1,
      WOSL_FL_VERIFY  = 2'h2
   } wosl_flash_kind_t;

   // Access state, Gray steps from the reset sample
   typedef enum logic [1:0] {
      WOSL_SAMPLE = 2'b00,
      WOSL_OPEN   = 2'b01,
      WOSL_LOCKED = 2'b10
   } wosl_state_t;

endpackage : wosl_pkg

// ### rtl/wosl_match_count.sv
// Super-majority match of latch cells against the lock pattern
`timescale 1ns/100ps
module wosl_match_count
   import wosl_pkg::*;
(
   // Cell contents
   input  wire logic [LATCH_BITS-1:0] cells,
   // Match result
   output logic [COUNT_W-1:0]         agree_count,
   output logic                       match
);

   // ==========================================================
   // Per-bit agreement
   logic [LATCH_BITS-1:0] agree;

   genvar g;
   generate
      for (g = 0; g < LATCH_BITS; g++) begin : g_agree
         assign agree[g] = ~(cells[g] ^ LOCK_PATTERN[g]);
      end
   endgenerate

   // Count of agreeing positions
   function automatic logic [COUNT_W-1:0] ones(input logic [LATCH_BITS-1:0] v);
      logic [COUNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < LATCH_BITS; i++) begin
         n = n + COUNT_W'(v[i]);
      end
      return n;
   endfunction : ones

   // Threshold compare, not an exact match
   always_comb begin
      agree_count = ones(agree);
      match       = (agree_count >= MATCH_MIN);
   end

endmodule : wosl_match_count

// ### rtl/wosl_security_lock.sv
// Write-once latch, reset-time lock sampling and flash protection gate
`timescale 1ns/100ps
module wosl_security_lock
   import wosl_pkg::*;
(
   // Clock and resets
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  por_n,
   // Command from debug port engine
   input  wire logic                  cmd_valid,
   input  wire logic [2:0]            cmd_op,
   input  wire logic [LATCH_BITS-1:0] cmd_data,
   input  wire logic [BLOCK_W-1:0]    cmd_block,
   input  wire logic [LEVEL_W-1:0]    cmd_level,
   input  wire logic [1:0]            cmd_kind,
   // Command answer
   output logic                       rsp_valid,
   output logic                       rsp_ok,
   output logic [LATCH_BITS-1:0]      rsp_data,
   // Access and status
   output logic                       port_access_en,
   output logic                       device_locked,
   output logic                       latch_match,
   output logic                       flash_prot_any
);

   // ==========================================================
   // Behaviour notes
   // Cells keep their value across device reset; only power-on clears them
   // Protection levels are kept the same way, so a lock reset keeps them
   // Lock state is taken once, at the first edge after reset release
   // Commands in that sampling cycle are refused; latch read still answers
   // A committed matching latch is frozen; later commits are refused
   // Chip erase clears protection levels only, never the latch or key

   // ==========================================================
   // Storage and state
   wosl_state_t             state;
   logic [LATCH_BITS-1:0]   vol_stage;
   logic [LATCH_BITS-1:0]   nv_cells;
   logic [LEVEL_W-1:0]      prot_level [FLASH_BLOCKS];
   logic                    match_now;
   logic                    take_any;
   logic                    open;
   logic                    prot_set_now;
   logic                    take_load;
   logic                    take_commit;
   logic                    take_read;
   logic                    take_prot;
   logic                    take_erase;
   logic                    take_flash;
   wosl_state_t             next_state;

   // Whether a flash operation kind is permitted at a level
   function automatic logic kind_allowed(input logic [1:0] kind,
                                         input logic [LEVEL_W-1:0] lvl);
      logic ok;
      ok = 1'b0;
      case (kind)
         WOSL_FL_ERASE:   ok = (lvl <= WRITE_MAX_LVL);
         WOSL_FL_PROGRAM: ok = (lvl <= WRITE_MAX_LVL);
         WOSL_FL_VERIFY:  ok = (lvl <= VERIFY_MAX_LVL);
         default:         ok = 1'b0;
      endcase
      return ok;
   endfunction : kind_allowed

   // ==========================================================
   // Match wrapper around the cells
   wosl_match_count u_match (
      .cells       (nv_cells),
      .agree_count (),
      .match       (match_now)
   );

   // ==========================================================
   // Command decode
   always_comb begin
      prot_set_now = 1'b0;
      for (int i = 0; i < FLASH_BLOCKS; i++) begin
         prot_set_now = prot_set_now | (prot_level[i] != LVL_NONE);
      end
   end

   // Only the open state grants programming and debug access
   assign open = (state == WOSL_OPEN);

   always_comb begin
      take_load   = 1'b0;
      take_commit = 1'b0;
      take_read   = 1'b0;
      take_prot   = 1'b0;
      take_erase  = 1'b0;
      take_flash  = 1'b0;
      if (cmd_valid) begin
         if (cmd_op == WOSL_CMD_LOAD_KEY) begin
            take_load = open && !prot_set_now;
         end else if (cmd_op == WOSL_CMD_COMMIT) begin
            // Cells can be rewritten until they match; a matching latch is frozen
            take_commit = open && !prot_set_now && !match_now;
         end else if (cmd_op == WOSL_CMD_READ_LATCH) begin
            take_read = 1'b1;
         end else if (cmd_op == WOSL_CMD_PROT_SET) begin
            take_prot = open && (cmd_level >= prot_level[cmd_block]);
         end else if (cmd_op == WOSL_CMD_CHIP_ERASE) begin
            take_erase = open;
         end else if (cmd_op == WOSL_CMD_FLASH_OP) begin
            take_flash = open && kind_allowed(cmd_kind, prot_level[cmd_block]);
         end
      end
   end

   // Any granted command
   assign take_any = take_load | take_commit | take_read
                   | take_prot | take_erase | take_flash;

   // ==========================================================
   // Reset-time lock sample
   always_comb begin
      next_state = state;
      case (state)
         WOSL_SAMPLE: next_state = match_now ? WOSL_LOCKED : WOSL_OPEN;
         WOSL_OPEN:   next_state = WOSL_OPEN;
         WOSL_LOCKED: next_state = WOSL_LOCKED;
         default:     next_state = WOSL_LOCKED;
      endcase
   end

   // Access state; closed until the first edge after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state          <= WOSL_SAMPLE;
         port_access_en <= 1'b0;
         device_locked  <= 1'b0;
      end else begin
         state          <= next_state;
         port_access_en <= (next_state == WOSL_OPEN);
         device_locked  <= (next_state == WOSL_LOCKED);
      end
   end

   // ==========================================================
   // Volatile key stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vol_stage <= VOL_RESET;
      end else if (take_load) begin
         vol_stage <= cmd_data;
      end
   end

   // Nonvolatile cells survive device reset, cleared only at power-on
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         nv_cells <= NV_BLANK;
      end else if (take_commit) begin
         nv_cells <= vol_stage;
      end
   end

   // ==========================================================
   // Flash protection levels, raise only, cleared by full erase
   // Levels are nonvolatile: a device reset must not clear them,
   // or a lock reset would drop the protection just programmed
   genvar b;
   generate
      for (b = 0; b < FLASH_BLOCKS; b++) begin : g_prot
         always_ff @(posedge clk or negedge por_n) begin
            if (!por_n) begin
               prot_level[b] <= LVL_NONE;
            end else if (take_erase) begin
               prot_level[b] <= LVL_NONE;
            end else if (take_prot && (cmd_block == BLOCK_W'(b))) begin
               prot_level[b] <= cmd_level;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Status flags
   // Live match shown even before a reset locks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_match    <= 1'b0;
         flash_prot_any <= 1'b0;
      end else begin
         latch_match    <= match_now;
         flash_prot_any <= prot_set_now;
      end
   end

   // ==========================================================
   // Command answer, one cycle after the command
   // Refused commands still answer, with rsp_ok low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_ok    <= 1'b0;
         rsp_data  <= RSP_RESET;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_ok    <= take_any;
         if (take_read) begin
            rsp_data <= nv_cells;
         end else begin
            rsp_data <= RSP_RESET;
         end
      end
   end

endmodule : wosl_security_lock

// ### verification/wosl_lock_properties.sv
// Port assertions for the security lock
`timescale 1ns/100ps
module wosl_lock_checker
   import wosl_pkg::*;
(
   // Clock, reset and command
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        cmd_valid,
   input wire logic [2:0]  cmd_op,
   // Answer and status
   input wire logic        rsp_valid,
   input wire logic        rsp_ok,
   input wire logic [31:0] rsp_data,
   input wire logic        port_access_en,
   input wire logic        device_locked,
   input wire logic        latch_match,
   input wire logic        flash_prot_any
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Access follows the lock sampled at reset
   lock_hold_a: assert property ($past(rst_n, 2) |-> $stable(device_locked)) else $error("lock moved");
   locked_shut_a: assert property (device_locked |-> !port_access_en) else $error("open while locked");
   key_open_a: assert property ($past(rst_n, 2) && !device_locked |-> port_access_en) else $error("shut");
   // Command answers
   lock_refuse_a: assert property (device_locked && cmd_valid && cmd_op != 3'h2 |=> !rsp_ok)
      else $error("granted while locked");
   read_grant_a: assert property (cmd_valid && cmd_op == 3'h2 |=> rsp_valid && rsp_ok) else $error("no read");
   key_prot_a: assert property (cmd_valid && cmd_op <= 3'h1 && flash_prot_any &&
      !($past(cmd_valid) && $past(cmd_op) == 3'h4) |=> !rsp_ok) else $error("key under protection");
   match_cnt_a: assert property (rsp_valid && rsp_ok && $past(cmd_op) == 3'h2 |->
      latch_match == ($countones(~(rsp_data ^ LOCK_PATTERN)) >= 28)) else $error("match flag wrong");
   prot_fall_a: assert property ($fell(flash_prot_any) |->
      $past(cmd_op) == 3'h4 && $past(cmd_valid) || $past(cmd_op, 2) == 3'h4 && $past(cmd_valid, 2))
      else $error("protection cleared without erase");
endmodule : wosl_lock_checker

// ### verification/wosl_programmer.sv
// Programmer model driving the lock command port
`timescale 1ns/100ps
module wosl_programmer
   import wosl_pkg::*;
(
   // Clock and answer
   input  wire logic        clk,
   input  wire logic        rsp_valid,
   input  wire logic        rsp_ok,
   input  wire logic [31:0] rsp_data,
   // Command
   output logic             cmd_valid,
   output logic [2:0]       cmd_op,
   output logic [31:0]      cmd_data,
   output logic [2:0]       cmd_block,
   output logic [1:0]       cmd_level,
   output logic [1:0]       cmd_kind
);
   // Idle command port
   initial {cmd_valid, cmd_op, cmd_data, cmd_block, cmd_level, cmd_kind} = '0;
   // Strobe for one cycle; answer read at the next falling edge, half a cycle after acceptance
   task automatic xfer(input logic [2:0] op, input logic [31:0] d, input logic [2:0] blk, input logic [1:0] lvl,
                       input logic [1:0] knd, output logic v, output logic ok, output logic [31:0] rd);
      @(negedge clk);
      {cmd_valid, cmd_op, cmd_data, cmd_block, cmd_level, cmd_kind} = {1'b1, op, d, blk, lvl, knd};
      @(negedge clk);
      {cmd_valid, cmd_data} = {1'b0, ~d}; // Data never keeps the last key
      {v, ok, rd} = {rsp_valid, rsp_ok, rsp_data};
   endtask : xfer
endmodule : wosl_programmer

// ### verification/tb.sv
// Self-checking bench for the security lock
`timescale 1ns/100ps
module tb
   import wosl_pkg::*;
;
   logic        clk = 1'b0;
   logic        por_n = 1'b0;
   logic        rst_n, cmd_valid, rsp_valid, rsp_ok, port_access_en, device_locked, latch_match, flash_prot_any;
   logic [2:0]  cmd_op, cmd_block;
   logic [1:0]  cmd_level, cmd_kind;
   logic [31:0] cmd_data, rsp_data, rd;
   int          bad_count = 0;
   int          n_tests = 0;
   // Block and programmer
   wosl_security_lock u_wosl_security_lock (.clk, .rst_n, .por_n, .cmd_valid, .cmd_op, .cmd_data, .cmd_block,
      .cmd_level, .cmd_kind, .rsp_valid, .rsp_ok, .rsp_data, .port_access_en, .device_locked, .latch_match,
      .flash_prot_any);
   wosl_programmer u_wosl_programmer (.clk, .rsp_valid, .rsp_ok, .rsp_data, .cmd_valid, .cmd_op, .cmd_data,
      .cmd_block, .cmd_level, .cmd_kind);
   // 200 MHz clock
   initial forever #2.5 clk = ~clk;
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) bad_count++;
      if (seen !== exp) $display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
   endtask : check
   // Command with expected grant
   task automatic issue(input logic [2:0] op, input logic ok_exp, input logic [31:0] d = '0,
                        input logic [2:0] blk = '0, input logic [1:0] lvl = '0, input logic [1:0] knd = '0);
      logic v, ok;
      u_wosl_programmer.xfer(op, d, blk, lvl, knd, v, ok, rd);
      check({v, ok}, {1'b1, ok_exp});
   endtask : issue
   // Reset for 10 cycles; lock sampled by the first edge after release
   task automatic dev_reset();
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      {por_n, rst_n} = 2'b11;
      repeat (2) @(negedge clk);
   endtask : dev_reset
   // Protection levels, key refusal and block permissions
   task automatic t_prot();
      issue(WOSL_CMD_PROT_SET, 1'b1, '0, 3'h2, 2'h1);
      issue(WOSL_CMD_PROT_SET, 1'b0, '0, 3'h2, 2'h0);
      issue(WOSL_CMD_LOAD_KEY, 1'b0, LOCK_PATTERN);
      for (int k = 0; k < 4; k++) begin
         issue(WOSL_CMD_FLASH_OP, k == 2, '0, 3'h2, '0, 2'(k));
         issue(WOSL_CMD_FLASH_OP, k != 3, '0, 3'h5, '0, 2'(k));
      end
      check(flash_prot_any, 1'b1);
      issue(WOSL_CMD_CHIP_ERASE, 1'b1);
      @(negedge clk);
      check(flash_prot_any, 1'b0);
   endtask : t_prot
   // Uncommitted key, near miss, threshold key, then lock by reset
   task automatic t_lock();
      issue(WOSL_CMD_LOAD_KEY, 1'b1, LOCK_PATTERN);
      dev_reset();
      check(device_locked, 1'b0);
      issue(WOSL_CMD_LOAD_KEY, 1'b1, LOCK_PATTERN ^ 32'h0000_001F);
      issue(WOSL_CMD_COMMIT, 1'b1);
      @(negedge clk);
      check(latch_match, 1'b0);
      issue(WOSL_CMD_LOAD_KEY, 1'b1, LOCK_PATTERN ^ 32'h8001_0810);
      issue(WOSL_CMD_COMMIT, 1'b1);
      @(negedge clk);
      check({latch_match, port_access_en}, 2'b11);
      issue(WOSL_CMD_COMMIT, 1'b0);
      issue(WOSL_CMD_PROT_SET, 1'b1, '0, 3'h0, 2'h2);
      dev_reset();
      check({port_access_en, device_locked}, 2'b01);
      check(flash_prot_any, 1'b1);
      issue(WOSL_CMD_READ_LATCH, 1'b1);
      check(rd, LOCK_PATTERN ^ 32'h8001_0810);
      issue(WOSL_CMD_FLASH_OP, 1'b0, '0, 3'h1, '0, 2'h2);
   endtask : t_lock
   // Verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   // Main sequence
   initial begin
      dev_reset();
      t_prot();
      t_lock();
      wrap_up();
   end
   // Watchdog, run needs about 80 cycles
   initial begin
      #5000;
      bad_count++;
      wrap_up();
   end
endmodule : tb
// Checker on the block ports
bind wosl_security_lock wosl_lock_checker u_chk (.clk, .rst_n, .cmd_valid, .cmd_op, .rsp_valid, .rsp_ok,
   .rsp_data, .port_access_en, .device_locked, .latch_match, .flash_prot_any);
